// *** rtl/acq_seq.sv ***
// camera acquisition sequencer: register port, frame flow, intensifier drive
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acq_seq
  import acq_seq_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic trig_in,  // external trigger line
  input wire logic [7:0] ttl_in,  // digital input lines
  input wire logic pulser_trig_in,  // internal pulse-timing trigger
  input wire logic nv_amp_in,  // stored amplifier default
  input wire logic nv_valid_in,  // stored default is ready
  output logic nv_wr_out,  // write amplifier default back
  output logic nv_amp_out,
  output intens_s intens_out,
  output logic clean_out,  // sensor clean in progress
  output logic integ_out,  // charge integrating
  output logic readout_out,  // frame readout in progress
  output logic frame_done_out,  // one-cycle pulse per stored frame
  output logic [15:0] pix_max_out,  // pixel full scale
  output logic busy_out
);

  // ***********************************
  // registers
  // ***********************************
  mode_s mode_q;
  logic [31:0] expo_q;
  logic [15:0] frames_q;
  logic [15:0] accum_q;
  logic [7:0] gain_q;
  logic [31:0] delay_q;
  logic ovr_q;
  logic loaded_q;  // amplifier default taken
  logic [15:0] fdone_q;

  logic wr_ctrl;
  assign wr_ctrl = wr_in && (addr_in == ctrl_off);
  logic start_cmd;
  assign start_cmd = wr_ctrl && wdata_in[ctrl_start_bit];

  // configuration writes; gain may change mid-acquisition
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_q <= '0;
      expo_q <= expo_rst;
      frames_q <= frames_rst;
      accum_q <= accum_rst;
      gain_q <= gain_rst;  // see R7
      delay_q <= delay_rst;
      loaded_q <= 1'b0;
    end else begin
      if (!loaded_q && nv_valid_in) begin
        mode_q.amp_fast <= nv_amp_in;  // see R5
        loaded_q <= 1'b1;
      end
      if (wr_in) begin
        unique case (addr_in)
          mode_off: begin
            mode_q <= mode_s'({20'h0_0000, wdata_in[11:0]});
          end
          expo_off: expo_q <= wdata_in;
          frames_off: frames_q <= wdata_in[15:0];
          accum_off: accum_q <= wdata_in[15:0];
          gain_off: gain_q <= wdata_in[7:0];  // see R7
          delay_off: delay_q <= wdata_in;
          default: begin
          end
        endcase
      end
    end
  end

  // write changed amplifier selection back as new default
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nv_wr_out <= 1'b0;
      nv_amp_out <= 1'b0;
    end else begin
      nv_wr_out <= wr_in && addr_in == mode_off && loaded_q
                   && wdata_in[mode_amp_bit] != mode_q.amp_fast;  // see R5
      // value held after the write so the store sees it beside the pulse
      if (wr_in && addr_in == mode_off) nv_amp_out <= wdata_in[mode_amp_bit];
    end
  end

  // full scale follows amplifier path
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) pix_max_out <= 16'h0fff;
    else pix_max_out <= mode_q.amp_fast ? 16'hffff : 16'h0fff;  // see R6
  end

  // ***********************************
  // input synchronisers
  // ***********************************
  logic [1:0] trig_sync_q;
  logic [1:0] ptrig_sync_q;
  logic [7:0] ttl_m_q;
  logic [7:0] ttl_s_q;
  logic trig_prev_q;
  logic ptrig_prev_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trig_sync_q <= 2'h0;
      ptrig_sync_q <= 2'h0;
      ttl_m_q <= 8'h00;
      ttl_s_q <= 8'h00;
      trig_prev_q <= 1'b0;
      ptrig_prev_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[0], trig_in};  // see R19
      ptrig_sync_q <= {ptrig_sync_q[0], pulser_trig_in};
      ttl_m_q <= ttl_in;  // see R19
      ttl_s_q <= ttl_m_q;
      trig_prev_q <= trig_sync_q[1];
      ptrig_prev_q <= ptrig_sync_q[1];
    end
  end

  logic ext_edge;
  logic int_edge;
  logic sync_edge;
  logic level_ok;
  assign ext_edge = mode_q.edge_fall ? (trig_prev_q && !trig_sync_q[1])
                                     : (!trig_prev_q && trig_sync_q[1]);  // see R17
  assign int_edge = !ptrig_prev_q && ptrig_sync_q[1];
  // internal sync only valid with shutter/gate and a pulser; taken here in any intensifier mode
  assign sync_edge = (mode_q.tmode == tmode_int) ? int_edge : ext_edge;  // see R9
  assign level_ok = ttl_s_q[mode_q.ttl_line];

  // ***********************************
  // sequencer
  // ***********************************
  typedef enum logic [2:0] {st_idle, st_level, st_arm, st_clean, st_expose,
                            st_read, st_hold, st_delay} seq_e;
  seq_e st_q;
  logic [31:0] cnt_q;
  logic [15:0] acc_q;
  logic frame_end;
  logic last_frame;
  logic [31:0] expo_eff;
  logic is_ext;
  assign is_ext = mode_q.tmode != tmode_free;
  assign last_frame = (fdone_q + 16'h0001) >= frames_q;
  assign frame_end = st_q == st_read && cnt_q == 32'h0 && acc_q <= 16'h0001;
  // shutter with internal sync integrates for zero time
  assign expo_eff = (mode_q.imode == imode_shutter && mode_q.tmode == tmode_int)
                    ? 32'h0 : expo_q;  // see R1

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= st_idle;
      cnt_q <= 32'h0;
      acc_q <= 16'h0;
      fdone_q <= 16'h0;
    end else begin
      unique case (st_q)
        st_idle, st_delay: begin
          if (st_q == st_delay && cnt_q != 32'h0) cnt_q <= cnt_q - 32'h1;
          if (start_cmd && !(st_q == st_delay && cnt_q != 32'h0)) begin
            if (st_q == st_idle) fdone_q <= 16'h0;
            acc_q <= accum_q;  // see R4
            st_q <= mode_q.wait_level ? st_level : st_arm;
          end
        end
        // level only gates the start; later changes are ignored
        st_level: if (level_ok) st_q <= st_arm;  // see R15
        st_arm: begin
          if (!is_ext || sync_edge) begin  // see R16
            cnt_q <= expo_eff;
            st_q <= (is_ext && mode_q.clean) ? st_clean : st_expose;
          end
        end
        st_clean: st_q <= st_expose;  // see R3
        st_expose: begin
          // zero exposure still valid: charge held since last read, see R2
          if (cnt_q == 32'h0) begin
            cnt_q <= {16'h0, read_cyc};
            st_q <= st_read;
          end else cnt_q <= cnt_q - 32'h1;
        end
        st_read: begin
          if (cnt_q != 32'h0) cnt_q <= cnt_q - 32'h1;
          else if (acc_q > 16'h0001) begin
            acc_q <= acc_q - 16'h1;  // see R4
            st_q <= is_ext ? st_arm : st_expose;
            cnt_q <= expo_eff;
          end else begin
            fdone_q <= fdone_q + 16'h1;
            acc_q <= accum_q;
            if (last_frame) st_q <= st_idle;
            else if (mode_q.fast) st_q <= is_ext ? st_arm : st_expose;  // see R12
            else st_q <= st_hold;  // see R13
            cnt_q <= expo_eff;
          end
        end
        st_hold: begin
          if (wr_ctrl && wdata_in[ctrl_host_done_bit]) begin
            cnt_q <= delay_q;  // see R14
            st_q <= st_delay;
          end
        end
        default: st_q <= st_idle;
      endcase
      if (wr_ctrl && wdata_in[ctrl_stop_bit]) st_q <= st_idle;
    end
  end

  // host buffer full level, set by host
  logic host_full_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) host_full_q <= 1'b0;
    else if (wr_ctrl) host_full_q <= wdata_in[ctrl_host_full_bit];
  end

  // sticky overrun, set wins over clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) ovr_q <= 1'b0;
    else if (frame_end && mode_q.fast && host_full_q) ovr_q <= 1'b1;  // see R18
    else if (wr_ctrl && (wdata_in[ctrl_clr_ovr_bit] || wdata_in[ctrl_start_bit]))
      ovr_q <= 1'b0;  // see R20
  end

  // ***********************************
  // intensifier and status outputs
  // ***********************************
  logic on_d;
  always_comb begin
    on_d = 1'b0;
    if (mode_q.imode == imode_shutter && mode_q.shut != shut_dis_closed) begin  // see R10
      on_d = st_q == st_expose;
      // early-open only with triggered timing
      if (mode_q.early_open && is_ext && (st_q == st_arm || st_q == st_level))
        on_d = 1'b1;  // see R11
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      intens_out <= '0;
      clean_out <= 1'b0;
      integ_out <= 1'b0;
      readout_out <= 1'b0;
      frame_done_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      intens_out.cathode_on <= on_d;  // see R8
      intens_out.gate_en <= mode_q.imode == imode_gate && st_q == st_expose
                            && mode_q.shut != shut_dis_closed;
      intens_out.gain <= gain_q;
      clean_out <= st_q == st_clean;
      integ_out <= st_q == st_expose;
      readout_out <= st_q == st_read;
      frame_done_out <= frame_end;
      busy_out <= st_q != st_idle;
    end
  end

  // register read port, data one cycle after strobe
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rdata_out <= 32'h0;
    else if (rd_in) begin
      unique case (addr_in)
        mode_off: rdata_out <= 32'(mode_q);
        expo_off: rdata_out <= expo_q;
        frames_off: rdata_out <= {16'h0, frames_q};
        accum_off: rdata_out <= {16'h0, accum_q};
        gain_off: rdata_out <= {24'h0, gain_q};
        delay_off: rdata_out <= delay_q;
        status_off: rdata_out <= {26'h0, host_full_q, ovr_q, 1'b0, 3'(st_q)};
        count_off: rdata_out <= {16'h0, fdone_q};
        default: rdata_out <= 32'h0;
      endcase
    end else rdata_out <= 32'h0;
  end

  // ***********************************
  // checks
  // ***********************************
  a_gain_live: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_in && addr_in == gain_off |=> ##1 intens_out.gain == $past(wdata_in[7:0], 2))  // see R7
    else $error("gain not applied");
  a_closed_dark: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    mode_q.shut == shut_dis_closed |=> !intens_out.cathode_on)  // see R10
    else $error("cathode gated while closed");
  a_safe_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    frame_end && !mode_q.fast && !last_frame |=> st_q == st_hold)  // see R13
    else $error("safe mode did not stop");
  a_level_gate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_q == st_level && !level_ok |=> st_q == st_level || st_q == st_idle)  // see R15
    else $error("started without level");
  a_ovr_sticky: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ovr_q && !wr_ctrl |=> ovr_q)  // see R20
    else $error("overrun flag lost");
  a_safe_intens: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    mode_q.imode == imode_safe |=> !intens_out.cathode_on && !intens_out.gate_en)  // see R8
    else $error("safe mode biased on");
  a_int_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_q == st_arm && mode_q.imode == imode_shutter && mode_q.tmode == tmode_int
    && int_edge |=> cnt_q == 32'h0)  // see R1
    else $error("exposure not forced zero");
  a_arm_wait: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_q == st_arm && is_ext && !sync_edge && !wr_ctrl |=> st_q == st_arm)  // see R17
    else $error("left arm without edge");

endmodule // acq_seq
`default_nettype wire

// *** rtl/acq_seq_pkg.sv ***
// constants and carrier types for the camera acquisition sequencer
// How it works
// R1 - shutter internal-sync forces exposure zero
// R2 - ext-trigger, no cleaning: zero exposure valid
// R3 - continuous cleaning clears charge before integration, with triggered timing only
// R4 - each frame sums accumulation-count exposures
// R5 - amplifier default loaded, changes written back
// R6 - high-capacity path gives 16-bit pixels
// R7 - gain 0..255, default 128, live
// R8 - shutter, gate and safe intensifier modes
// R9 - external or internal sync, mode-limited; code takes internal sync in any intensifier mode
// R10 - disabled-closed never gates photocathode
// R11 - early-open biases photocathode before start
// R12 - fast mode runs all frames unattended
// R13 - safe mode stops after each frame
// R14 - inter-frame delay only in safe mode
// R15 - wait-for-level gates start, not halt
// R16 - level seen, then still wait trigger edge
// R17 - trigger edge rising or falling selectable
// R18 - fast mode flags data overrun
// R19 - trigger, pulser and digital inputs pass two-stage synchroniser
// R20 - overrun flag sticky until clear or start
package acq_seq_pkg;

  // ***********************************
  // register map
  // ***********************************
  localparam logic [3:0] ctrl_off = 4'h0;  // command bits
  localparam logic [3:0] mode_off = 4'h1;  // mode configuration
  localparam logic [3:0] expo_off = 4'h2;  // exposure cycles
  localparam logic [3:0] frames_off = 4'h3;  // frame count
  localparam logic [3:0] accum_off = 4'h4;  // accumulation count
  localparam logic [3:0] gain_off = 4'h5;  // intensifier gain
  localparam logic [3:0] delay_off = 4'h6;  // inter-frame delay cycles
  localparam logic [3:0] status_off = 4'h7;  // status, read only
  localparam logic [3:0] count_off = 4'h8;  // frames done, read only

  // ***********************************
  // control and mode bit positions
  // ***********************************
  localparam int ctrl_start_bit = 0;
  localparam int ctrl_stop_bit = 1;
  localparam int ctrl_clr_ovr_bit = 2;
  localparam int ctrl_host_done_bit = 3;  // host finished processing frame
  localparam int ctrl_host_full_bit = 4;  // host buffer cannot take frame
  localparam int mode_amp_bit = 10;  // amplifier path bit of a mode write

  // ***********************************
  // reset values
  // ***********************************
  localparam logic [7:0] gain_rst = 8'h80;
  localparam logic [15:0] frames_rst = 16'h0001;
  localparam logic [15:0] accum_rst = 16'h0001;
  localparam logic [31:0] expo_rst = 32'h0000_0000;
  localparam logic [31:0] delay_rst = 32'h0000_0000;
  localparam logic [15:0] read_cyc = 16'h0010;  // readout stand-in length
  localparam int sync_stages = 2;

  typedef enum logic [1:0] {imode_shutter, imode_gate, imode_safe} imode_e;
  typedef enum logic [1:0] {tmode_free, tmode_ext, tmode_int} tmode_e;
  typedef enum logic [1:0] {shut_normal, shut_dis_closed, shut_dis_open} shut_e;

  // mode register layout, high bits first
  typedef struct packed {
    logic [16:0] rsvd;  // pads the layout to one 32-bit word
    logic [2:0] ttl_line;  // digital input line watched
    logic wait_level;  // gate start on high level
    logic amp_fast;  // high-capacity amplifier
    logic edge_fall;  // trigger on falling edge
    logic fast;  // fast flow, else safe
    logic clean;  // continuous cleaning
    logic early_open;
    shut_e shut;
    logic [1:0] tmode;
    logic [1:0] imode;
  } mode_s;

  // intensifier drive toward the head
  typedef struct packed {
    logic cathode_on;  // photocathode biased on
    logic gate_en;  // pulser gating allowed
    logic [7:0] gain;
  } intens_s;

endpackage

// *** verif/acq_far_side.sv ***
// far-side model: trigger source, digital lines, pulser and stored amplifier default
`timescale 1ns/1ps
`default_nettype none
module acq_far_side (
  input wire logic clk_in,
  input wire logic rst_b_in,
  output logic trig_out,
  output logic [7:0] ttl_out,
  output logic pulser_out,
  output logic nv_amp_out,
  output logic nv_valid_out
);
  logic [3:0] wake_q;  // cycles since reset release, held at 15

  initial begin
    trig_out = 1'b0;
    ttl_out = 8'h00;
    pulser_out = 1'b0;
  end

  // internal trigger: one-cycle pulse, launched right after an edge
  task automatic pulse_pulser;
    @(posedge clk_in);
    pulser_out <= 1'b1;
    @(posedge clk_in);
    pulser_out <= 1'b0;
  endtask

  // stored default turns up a few cycles late, as a slow memory would
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wake_q <= 4'h0;
    end else if (wake_q != 4'hf) begin
      wake_q <= wake_q + 4'h1;
    end
  end
  assign nv_valid_out = (wake_q >= 4'h3);
  // before valid the data line toggles so a stale value is never trusted
  assign nv_amp_out = nv_valid_out ? 1'b1 : wake_q[0];

  // trigger level changes right after an edge
  task automatic set_trig(input logic v);
    @(posedge clk_in);
    trig_out <= v;
  endtask

  // digital lines change right after an edge
  task automatic set_ttl(input logic [7:0] v);
    @(posedge clk_in);
    ttl_out <= v;
  endtask
endmodule  // acq_far_side
`default_nettype wire

// *** verif/acq_seq_tb.sv ***
// self-checking testbench for the acquisition sequencer
`timescale 1ns/1ps
`default_nettype none
module camera_acquisition_sequencer_tb;
  import acq_seq_pkg::*;
  // ***********************************
  // stimulus and observation
  // ***********************************
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic trig, pulser, nv_amp, nv_valid, nv_wr, nv_amp_o;
  logic [7:0] ttl;
  intens_s intens;
  logic clean, integ, readout, done, busy;
  logic [15:0] pix_max;
  int err_total = 0;
  int num_checks = 0;
  int n_done = 0;  // frame pulses seen
  int n_integ = 0;  // integration starts seen
  int n_cath = 0;  // cycles with photocathode on
  int n_nvwr = 0;  // stored default writes
  int n_clean = 0;  // cycles with cleaning
  int n_gate = 0;  // cycles with pulser gating allowed
  int n_rd = 0;  // cycles of readout
  int n_intc = 0;  // cycles of integration
  int g, r, ci, cl;
  logic integ_q = 1'b0;
  logic [31:0] rv;
  int b, c;
  logic [1:0] im_tab [3] = '{imode_shutter, imode_safe, imode_gate};
  logic [1:0] sh_tab [3] = '{shut_dis_closed, shut_normal, shut_normal};

  always #12.5 clk_in = ~clk_in;

  acq_seq DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .trig_in(trig), .ttl_in(ttl),
    .pulser_trig_in(pulser), .nv_amp_in(nv_amp), .nv_valid_in(nv_valid), .nv_wr_out(nv_wr),
    .nv_amp_out(nv_amp_o), .intens_out(intens), .clean_out(clean), .integ_out(integ),
    .readout_out(readout), .frame_done_out(done), .pix_max_out(pix_max), .busy_out(busy));

  acq_far_side u_far (.clk_in(clk_in), .rst_b_in(rst_b_in), .trig_out(trig), .ttl_out(ttl),
    .pulser_out(pulser), .nv_amp_out(nv_amp), .nv_valid_out(nv_valid));

  // event counters; compared as differences so no clearing is needed
  always @(posedge clk_in) begin
    integ_q <= integ;
    if (done === 1'b1) n_done <= n_done + 1;
    if (integ === 1'b1 && integ_q !== 1'b1) n_integ <= n_integ + 1;
    if (intens.cathode_on === 1'b1) n_cath <= n_cath + 1;
    if (nv_wr === 1'b1) n_nvwr <= n_nvwr + 1;
    if (clean === 1'b1) n_clean <= n_clean + 1;
    if (intens.gate_en === 1'b1) n_gate <= n_gate + 1;
    if (readout === 1'b1) n_rd <= n_rd + 1;
    if (integ === 1'b1) n_intc <= n_intc + 1;
  end

  // ***********************************
  // tasks
  // ***********************************
  task automatic close_out;
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // bounded wait for a total frame count
  task automatic wait_done(input int want);
    for (int i = 0; i < 2000 && n_done < want; i++) @(posedge clk_in);
    if (n_done < want) begin
      err_total++;
      $display("ERROR frame wait expected %0d seen %0d", want, n_done);
      close_out();
    end
  endtask

  function automatic logic [31:0] mk(input logic [1:0] im, input logic [1:0] tm,
      input logic [1:0] sh, input logic fast, input logic fall, input logic wl);
    mode_s m;
    m = '0;
    m.imode = im;
    m.tmode = tm;
    m.shut = shut_e'(sh);
    m.fast = fast;
    m.edge_fall = fall;
    m.wait_level = wl;
    return m;
  endfunction

  task automatic setup(input logic [31:0] m, input logic [15:0] fr, input logic [31:0] ex);
    wr_reg(mode_off, m);
    wr_reg(frames_off, {16'h0, fr});
    wr_reg(accum_off, 32'h1);
    wr_reg(expo_off, ex);
    b = n_done;
    c = n_cath;
    g = n_gate;
  endtask

  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    idle(12);
    rst_b_in <= 1'b1;
    idle(10);
    chk("gain out", 32'h80, {24'h0, intens.gain});
    rd_reg(gain_off, rv);
    chk("gain reg", 32'h80, rv);
    chk("pix max fast", 32'hffff, {16'h0, pix_max});
    rd_reg(mode_off, rv);
    chk("amp bit", 32'h1, {31'h0, rv[10]});
    // leaving the high-capacity path must be stored back
    setup(mk(imode_shutter, tmode_free, shut_normal, 1'b1, 1'b0, 1'b0), 16'h3, 32'h4);
    chk("nv writes", 32'h1, n_nvwr);
    chk("nv value", 32'h0, {31'h0, nv_amp_o});
    chk("pix max slow", 32'h0fff, {16'h0, pix_max});
    // fast flow: three frames of two exposures from one start
    wr_reg(accum_off, 32'h2);
    c = n_integ;
    r = n_rd;
    wr_reg(ctrl_off, 32'h1);
    idle(6);
    wr_reg(gain_off, 32'h37);
    idle(2);
    chk("gain live", 32'h37, {24'h0, intens.gain});
    chk("busy run", 32'h1, {31'h0, busy});
    wait_done(b + 3);
    idle(60);
    chk("fast frames", 32'h3, n_done - b);
    chk("exposures", 32'h6, n_integ - c);
    chk("readouts", 6 * (int'(read_cyc) + 1), n_rd - r);
    chk("busy idle", 32'h0, {31'h0, busy});
    rd_reg(count_off, rv);
    chk("count reg", 32'h3, rv);
    // photocathode must stay dark in these settings
    for (int k = 0; k < 3; k++) begin
      setup(mk(im_tab[k], tmode_free, sh_tab[k], 1'b1, 1'b0, 1'b0), 16'h1, 32'h4);
      wr_reg(ctrl_off, 32'h1);
      wait_done(b + 1);
      chk("cathode dark", 32'h0, n_cath - c);
      chk("gate lit", {31'h0, k == 2}, {31'h0, n_gate > g});
    end
    // paced flow: stop per frame, start during delay is dropped
    setup(mk(imode_shutter, tmode_free, shut_normal, 1'b0, 1'b0, 1'b0), 16'h2, 32'h4);
    wr_reg(delay_off, 32'h1e);
    wr_reg(ctrl_off, 32'h1);
    wait_done(b + 1);
    idle(60);
    chk("paced stop", 32'h1, n_done - b);
    wr_reg(ctrl_off, 32'h8);
    wr_reg(ctrl_off, 32'h1);
    idle(60);
    chk("delay drop", 32'h1, n_done - b);
    wr_reg(ctrl_off, 32'h1);
    wait_done(b + 2);
    chk("cathode lit", 32'h1, {31'h0, n_cath > c});
    // external falling edge, gated by a level, zero exposure
    u_far.set_trig(1'b1);
    setup(mk(imode_shutter, tmode_ext, shut_normal, 1'b1, 1'b1, 1'b1), 16'h1, 32'h0);
    wr_reg(ctrl_off, 32'h1);
    idle(5);
    u_far.set_trig(1'b0);
    idle(40);
    chk("level gate", 32'h0, n_done - b);
    u_far.set_ttl(8'h01);
    idle(10);
    u_far.set_trig(1'b1);
    idle(40);
    chk("edge wait", 32'h0, n_done - b);
    u_far.set_trig(1'b0);
    idle(6);
    u_far.set_ttl(8'h00);
    wait_done(b + 1);
    // internal sync: early-open bias while armed, cleaned, exposure forced to zero
    setup(mk(imode_shutter, tmode_int, shut_dis_open, 1'b1, 1'b0, 1'b0) | 32'hc0, 16'h1, 32'h28);
    ci = n_intc;
    cl = n_clean;
    wr_reg(ctrl_off, 32'h1);
    idle(10);
    chk("early open", 32'h1, {31'h0, intens.cathode_on});
    chk("busy armed", 32'h1, {31'h0, busy});
    u_far.pulse_pulser();
    wait_done(b + 1);
    chk("int exposure", 32'h1, n_intc - ci);
    chk("cleaned", 32'h1, {31'h0, n_clean > cl});
    // overrun sets while the host is full and clears on request
    setup(mk(imode_shutter, tmode_free, shut_normal, 1'b1, 1'b0, 1'b0), 16'h2, 32'h28);
    wr_reg(ctrl_off, 32'h1);
    idle(4);
    wr_reg(ctrl_off, 32'h10);
    wait_done(b + 1);
    rd_reg(status_off, rv);
    chk("overrun set", 32'h1, {31'h0, rv[4]});
    wr_reg(ctrl_off, 32'h4);
    idle(2);
    rd_reg(status_off, rv);
    chk("overrun clear", 32'h0, {31'h0, rv[4]});
    wait_done(b + 2);
    close_out();
  end
endmodule  // camera_acquisition_sequencer_tb
`default_nettype wire
